// *** core/ids_debounce.sv ***
`timescale 1ns/1ps
`default_nettype none

module ids_debounce #(
  parameter logic RESET_LEVEL = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  input wire logic tick,
  input wire logic [6:0] len,
  output logic level
);

  logic [2:0] sync_q, sync_d;
  logic lvl_q, lvl_d;
  logic [6:0] cnt_q, cnt_d;

  always_comb begin
    sync_d = {sync_q[1:0], pin};
    lvl_d = lvl_q;
    cnt_d = cnt_q;
    if (sync_q[2] != sync_q[1] || sync_q[2] == lvl_q) begin
      cnt_d = 7'h00;
    end else if (len == 7'h00) begin
      lvl_d = sync_q[2];
    end else if (tick) begin
      // Tick phase is free running, so wait one extra tick to never be short
      if (cnt_q >= len) begin
        lvl_d = sync_q[2];
        cnt_d = 7'h00;
      end else begin
        cnt_d = cnt_q + 7'h01;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_q <= {3{RESET_LEVEL}};
      lvl_q <= RESET_LEVEL;
      cnt_q <= 7'h00;
    end else begin
      sync_q <= sync_d;
      lvl_q <= lvl_d;
      cnt_q <= cnt_d;
    end
  end

  assign level = lvl_q;

endmodule

`default_nettype wire

// *** core/ids_defs.svh ***
`ifndef IDS_DEFS_SVH
`define IDS_DEFS_SVH

// ****************************************
// Timing
// ****************************************
`define IDS_CLK_PERIOD_PS 5000
`define IDS_FILTER_UNIT_US 64
`define IDS_WDT_UNIT_US 800
`define IDS_STEP_UNIT_US 1000
`define IDS_FILTER_UNIT_CYC ((`IDS_FILTER_UNIT_US * 1000000) / `IDS_CLK_PERIOD_PS)
`define IDS_WDT_UNIT_CYC ((`IDS_WDT_UNIT_US * 1000000) / `IDS_CLK_PERIOD_PS)
`define IDS_STEP_UNIT_CYC ((`IDS_STEP_UNIT_US * 1000000) / `IDS_CLK_PERIOD_PS)

// ****************************************
// Register indices, byte address is four times the index
// ****************************************
`define IDS_IDX_OUT_CTRL 6'h06
`define IDS_IDX_STEP 6'h07
`define IDS_IDX_OUT3_STOP 6'h0C
`define IDS_IDX_OUT4_STOP 6'h0D
`define IDS_IDX_WDT_FILTER 6'h0E
`define IDS_IDX_FUNC 6'h0F
`define IDS_IDX_PIN_FILTER 6'h10
`define IDS_IDX_GPI_FILTER 6'h11
`define IDS_IDX_STATUS 6'h18

// ****************************************
// Reset values and fields
// ****************************************
`define IDS_RST_OUT_CTRL 8'h00
`define IDS_RST_STEP 8'h00
`define IDS_RST_OUT3_STOP 8'h00
`define IDS_RST_OUT4_STOP 8'h00
`define IDS_RST_WDT_FILTER 8'h02
`define IDS_RST_FUNC 8'h43
`define IDS_RST_PIN_FILTER 8'h11
`define IDS_RST_GPI_FILTER 8'h11
`define IDS_STEP_SEL_BIT 7
`define IDS_DELAY_FIELD 4:0
`define IDS_WDT_FIELD 2:0
`define IDS_NIB_HI 7:4
`define IDS_NIB_LO 3:0
`define IDS_CTRL_GLB_BIT 0
`define IDS_CTRL_OUT_FIELD 4:1

// ****************************************
// Input function codes
// ****************************************
`define IDS_FN_GLOBAL_ENABLE 4'h0
`define IDS_FN_EN_FIRST 4'h1
`define IDS_FN_GLOBAL_VOLTAGE_SELECT 4'h5
`define IDS_FN_VSEL_FIRST 4'h6
`define IDS_FN_GLB_LP 4'hA
`define IDS_FN_LP_FIRST 4'hB

`endif

// *** core/ids_pkg.sv ***
package ids_pkg;

  typedef struct packed {
    logic global_enable;
    logic [3:0] en;
    logic global_voltage_select;
    logic [3:0] vsel;
    logic glb_lp;
    logic [1:0] lp;
  } ids_route_t;

  typedef struct packed {
    logic wdt_n;
    logic in_b;
    logic in_a;
    logic lp;
    logic en;
  } ids_pins_t;

  typedef enum logic [1:0] {
    ST_ON,
    ST_WAIT,
    ST_OFF
  } ids_stop_state_t;

endpackage

// *** core/ids_stop_delay.sv ***
`timescale 1ns/1ps
`default_nettype none

module ids_stop_delay (
  input wire logic clk,
  input wire logic rst,
  input wire logic src,
  input wire logic tick,
  input wire logic [4:0] code,
  output logic hold
);

  ids_pkg::ids_stop_state_t state_q, state_d;
  logic [4:0] cnt_q, cnt_d;
  logic hold_q, hold_d;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      ids_pkg::ST_ON: begin
        cnt_d = 5'h00;
        if (!src) begin
          state_d = (code == 5'h00) ? ids_pkg::ST_OFF : ids_pkg::ST_WAIT;
        end
      end
      ids_pkg::ST_WAIT: begin
        if (src) begin
          state_d = ids_pkg::ST_ON;
        end else if (tick) begin
          // Compare with >= so a code lowered mid wait still ends it
          if (cnt_q >= code) begin
            state_d = ids_pkg::ST_OFF;
          end else begin
            cnt_d = cnt_q + 5'h01;
          end
        end
      end
      ids_pkg::ST_OFF: begin
        if (src) begin
          state_d = ids_pkg::ST_ON;
        end
      end
      default: begin
        state_d = ids_pkg::ST_OFF;
      end
    endcase
    hold_d = (state_d != ids_pkg::ST_OFF);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ids_pkg::ST_OFF;
      cnt_q <= 5'h00;
      hold_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      hold_q <= hold_d;
    end
  end

  assign hold = hold_q;

endmodule

`default_nettype wire

// *** core/ids_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ids_defs.svh"

// Functional notes
// - Output 3 holds a 5-bit stop delay, reset zero, counted in steps after the global enable falls.
// - Output 4 holds a 5-bit stop delay, reset zero, code times step, zero meaning immediate.
// - The watchdog input filter code selects none, or 0.8 ms doubling up to 51.2 ms, reset 1.6 ms.
// - Function codes 0 to 4 route a general input to the global enable or to outputs 1 to 4 enables.
// - Function codes 5 to 9 route a general input to the global or per-output voltage select.
// - Function codes A to C route a general input to the global or output 1 and 2 low power.
// - After reset input b drives output 4 enable and input a drives output 3 enable.
// - Low power pin and enable pin filters take code times 64 us and reset to code 1.
// - General input filters take code times 64 us, zero is none, and reset to code 1.
// - Input a filter uses all sixteen codes, up to 960 us.
// - The delay step is 1 ms with the select bit clear and 2 ms with it set.
// - Each output enable is the OR of its register bit, any general input routed to it, and global on (outputs 1, 2) or its stop delay hold (3, 4).
module ids_top #(
  parameter int unsigned FILTER_CYCLES = `IDS_FILTER_UNIT_CYC,
  parameter int unsigned WDT_CYCLES = `IDS_WDT_UNIT_CYC,
  parameter int unsigned STEP_CYCLES = `IDS_STEP_UNIT_CYC
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic ENABLE_PIN,
  input wire logic LOW_POWER_PIN,
  input wire logic WATCHDOG_RESET_INPUT_N,
  input wire logic GENERAL_INPUT_A,
  input wire logic GENERAL_INPUT_B,
  output logic [3:0] OUT_ENABLE,
  output logic GLOBAL_VOLTAGE_SELECT,
  output logic [3:0] OUT_VOLTAGE_SELECT,
  output logic GLOBAL_LOW_POWER,
  output logic [1:0] OUT_LOW_POWER,
  output logic WATCHDOG_RESET_N
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic reg_hit(input logic [7:0] adr, input logic [5:0] idx);
    reg_hit = (adr[7:2] == idx);
  endfunction

  function automatic logic [6:0] wdt_len(input logic [2:0] code);
    case (code)
      3'h0: wdt_len = 7'h00;
      3'h1: wdt_len = 7'h01;
      3'h2: wdt_len = 7'h02;
      3'h3: wdt_len = 7'h04;
      3'h4: wdt_len = 7'h08;
      3'h5: wdt_len = 7'h10;
      3'h6: wdt_len = 7'h20;
      default: wdt_len = 7'h40;
    endcase
  endfunction

  function automatic ids_pkg::ids_route_t route_of(input logic [3:0] code, input logic lvl);
    ids_pkg::ids_route_t r;
    r = '0;
    if (code == `IDS_FN_GLOBAL_ENABLE) r.global_enable = lvl;
    if (code == `IDS_FN_GLOBAL_VOLTAGE_SELECT) r.global_voltage_select = lvl;
    if (code == `IDS_FN_GLB_LP) r.glb_lp = lvl;
    for (int i = 0; i < 4; i++) begin
      if (code == 4'(`IDS_FN_EN_FIRST + i)) r.en[i] = lvl;
      if (code == 4'(`IDS_FN_VSEL_FIRST + i)) r.vsel[i] = lvl;
    end
    for (int i = 0; i < 2; i++) begin
      if (code == 4'(`IDS_FN_LP_FIRST + i)) r.lp[i] = lvl;
    end
    route_of = r;
  endfunction

  // ****************************************
  // Bus slave
  // ****************************************
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic req;
  logic wr_en;
  logic [31:0] rd_word;

  logic [4:0] out3_stop_delay_code_q, out3_stop_delay_code_d;
  logic [4:0] out4_stop_delay_code_q, out4_stop_delay_code_d;
  logic [2:0] watchdog_input_filter_code_q, watchdog_input_filter_code_d;
  logic [3:0] input_a_function_code_q, input_a_function_code_d;
  logic [3:0] input_b_function_code_q, input_b_function_code_d;
  logic [3:0] low_power_pin_filter_code_q, low_power_pin_filter_code_d;
  logic [3:0] enable_pin_filter_code_q, enable_pin_filter_code_d;
  logic [3:0] input_a_filter_code_q, input_a_filter_code_d;
  logic [3:0] input_b_filter_code_q, input_b_filter_code_d;
  logic delay_step_select_q, delay_step_select_d;
  logic global_enable_q, global_enable_d;
  logic [3:0] out_enable_bits_q, out_enable_bits_d;

  logic [3:0] out_en_q, out_en_d;
  ids_pkg::ids_pins_t pins;

  assign req = WB_CYC_I & WB_STB_I;
  // Writes land on the edge where the master sees ack
  assign wr_en = req & WB_WE_I & ack_q & WB_SEL_I[0];

  always_comb begin
    rd_word = 32'h0000_0000;
    case (WB_ADR_I[7:2])
      `IDS_IDX_OUT_CTRL: rd_word = {27'h0, out_enable_bits_q, global_enable_q};
      `IDS_IDX_STEP: rd_word = {24'h0, delay_step_select_q, 7'h00};
      `IDS_IDX_OUT3_STOP: rd_word = {27'h0, out3_stop_delay_code_q};
      `IDS_IDX_OUT4_STOP: rd_word = {27'h0, out4_stop_delay_code_q};
      `IDS_IDX_WDT_FILTER: rd_word = {29'h0, watchdog_input_filter_code_q};
      `IDS_IDX_FUNC: rd_word = {24'h0, input_b_function_code_q, input_a_function_code_q};
      `IDS_IDX_PIN_FILTER: rd_word = {24'h0, low_power_pin_filter_code_q, enable_pin_filter_code_q};
      `IDS_IDX_GPI_FILTER: rd_word = {24'h0, input_b_filter_code_q, input_a_filter_code_q};
      `IDS_IDX_STATUS: rd_word = {23'h0, pins, out_en_q};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_comb begin
    ack_d = req & ~ack_q;
    rdat_d = rdat_q;
    // Writes leave the last read word standing
    if (req & ~ack_q & ~WB_WE_I) begin
      rdat_d = rd_word;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = rdat_q;

  // ****************************************
  // Registers
  // ****************************************
  always_comb begin
    out3_stop_delay_code_d = out3_stop_delay_code_q;
    out4_stop_delay_code_d = out4_stop_delay_code_q;
    watchdog_input_filter_code_d = watchdog_input_filter_code_q;
    input_a_function_code_d = input_a_function_code_q;
    input_b_function_code_d = input_b_function_code_q;
    low_power_pin_filter_code_d = low_power_pin_filter_code_q;
    enable_pin_filter_code_d = enable_pin_filter_code_q;
    input_a_filter_code_d = input_a_filter_code_q;
    input_b_filter_code_d = input_b_filter_code_q;
    delay_step_select_d = delay_step_select_q;
    global_enable_d = global_enable_q;
    out_enable_bits_d = out_enable_bits_q;
    if (wr_en) begin
      if (reg_hit(WB_ADR_I, `IDS_IDX_OUT_CTRL)) begin
        global_enable_d = WB_DAT_I[`IDS_CTRL_GLB_BIT];
        out_enable_bits_d = WB_DAT_I[`IDS_CTRL_OUT_FIELD];
      end
      if (reg_hit(WB_ADR_I, `IDS_IDX_STEP)) begin
        delay_step_select_d = WB_DAT_I[`IDS_STEP_SEL_BIT];
      end
      if (reg_hit(WB_ADR_I, `IDS_IDX_OUT3_STOP)) begin
        out3_stop_delay_code_d = WB_DAT_I[`IDS_DELAY_FIELD];
      end
      if (reg_hit(WB_ADR_I, `IDS_IDX_OUT4_STOP)) begin
        out4_stop_delay_code_d = WB_DAT_I[`IDS_DELAY_FIELD];
      end
      if (reg_hit(WB_ADR_I, `IDS_IDX_WDT_FILTER)) begin
        watchdog_input_filter_code_d = WB_DAT_I[`IDS_WDT_FIELD];
      end
      if (reg_hit(WB_ADR_I, `IDS_IDX_FUNC)) begin
        input_b_function_code_d = WB_DAT_I[`IDS_NIB_HI];
        input_a_function_code_d = WB_DAT_I[`IDS_NIB_LO];
      end
      if (reg_hit(WB_ADR_I, `IDS_IDX_PIN_FILTER)) begin
        low_power_pin_filter_code_d = WB_DAT_I[`IDS_NIB_HI];
        enable_pin_filter_code_d = WB_DAT_I[`IDS_NIB_LO];
      end
      if (reg_hit(WB_ADR_I, `IDS_IDX_GPI_FILTER)) begin
        input_b_filter_code_d = WB_DAT_I[`IDS_NIB_HI];
        input_a_filter_code_d = WB_DAT_I[`IDS_NIB_LO];
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      out3_stop_delay_code_q <= 5'(`IDS_RST_OUT3_STOP);
      out4_stop_delay_code_q <= 5'(`IDS_RST_OUT4_STOP);
      watchdog_input_filter_code_q <= 3'(`IDS_RST_WDT_FILTER);
      input_b_function_code_q <= 4'(`IDS_RST_FUNC >> 4);
      input_a_function_code_q <= 4'(`IDS_RST_FUNC);
      low_power_pin_filter_code_q <= 4'(`IDS_RST_PIN_FILTER >> 4);
      enable_pin_filter_code_q <= 4'(`IDS_RST_PIN_FILTER);
      input_b_filter_code_q <= 4'(`IDS_RST_GPI_FILTER >> 4);
      input_a_filter_code_q <= 4'(`IDS_RST_GPI_FILTER);
      delay_step_select_q <= 1'(`IDS_RST_STEP >> `IDS_STEP_SEL_BIT);
      global_enable_q <= 1'(`IDS_RST_OUT_CTRL);
      out_enable_bits_q <= 4'(`IDS_RST_OUT_CTRL >> 1);
    end else begin
      out3_stop_delay_code_q <= out3_stop_delay_code_d;
      out4_stop_delay_code_q <= out4_stop_delay_code_d;
      watchdog_input_filter_code_q <= watchdog_input_filter_code_d;
      input_b_function_code_q <= input_b_function_code_d;
      input_a_function_code_q <= input_a_function_code_d;
      low_power_pin_filter_code_q <= low_power_pin_filter_code_d;
      enable_pin_filter_code_q <= enable_pin_filter_code_d;
      input_b_filter_code_q <= input_b_filter_code_d;
      input_a_filter_code_q <= input_a_filter_code_d;
      delay_step_select_q <= delay_step_select_d;
      global_enable_q <= global_enable_d;
      out_enable_bits_q <= out_enable_bits_d;
    end
  end

  // ****************************************
  // Time base
  // ****************************************
  logic [19:0] fcnt_q, fcnt_d;
  logic [19:0] wcnt_q, wcnt_d;
  logic [19:0] scnt_q, scnt_d;
  logic half_q, half_d;
  logic filter_tick;
  logic wdt_tick;
  logic ms_tick;
  logic step_tick;

  assign filter_tick = (fcnt_q == 20'(FILTER_CYCLES - 1));
  assign wdt_tick = (wcnt_q == 20'(WDT_CYCLES - 1));
  assign ms_tick = (scnt_q == 20'(STEP_CYCLES - 1));
  // 1 ms or 2 ms step
  assign step_tick = ms_tick & (~delay_step_select_q | half_q);

  always_comb begin
    fcnt_d = filter_tick ? 20'h00000 : fcnt_q + 20'h00001;
    wcnt_d = wdt_tick ? 20'h00000 : wcnt_q + 20'h00001;
    scnt_d = ms_tick ? 20'h00000 : scnt_q + 20'h00001;
    half_d = ms_tick ? ~half_q : half_q;
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      fcnt_q <= 20'h00000;
      wcnt_q <= 20'h00000;
      scnt_q <= 20'h00000;
      half_q <= 1'b0;
    end else begin
      fcnt_q <= fcnt_d;
      wcnt_q <= wcnt_d;
      scnt_q <= scnt_d;
      half_q <= half_d;
    end
  end

  // ****************************************
  // Input filters
  // ****************************************
  // Enable pin filter
  ids_debounce #(.RESET_LEVEL(1'b0)) u_en_filter (
    .clk(CLK), .rst(RST), .pin(ENABLE_PIN), .tick(filter_tick),
    .len({3'h0, enable_pin_filter_code_q}), .level(pins.en)
  );

  ids_debounce #(.RESET_LEVEL(1'b0)) u_lp_filter (
    .clk(CLK), .rst(RST), .pin(LOW_POWER_PIN), .tick(filter_tick),
    .len({3'h0, low_power_pin_filter_code_q}), .level(pins.lp)
  );

  // Full code range on input a
  ids_debounce #(.RESET_LEVEL(1'b0)) u_a_filter (
    .clk(CLK), .rst(RST), .pin(GENERAL_INPUT_A), .tick(filter_tick),
    .len({3'h0, input_a_filter_code_q}), .level(pins.in_a)
  );

  ids_debounce #(.RESET_LEVEL(1'b0)) u_b_filter (
    .clk(CLK), .rst(RST), .pin(GENERAL_INPUT_B), .tick(filter_tick),
    .len({3'h0, input_b_filter_code_q}), .level(pins.in_b)
  );

  ids_debounce #(.RESET_LEVEL(1'b1)) u_wdt_filter (
    .clk(CLK), .rst(RST), .pin(WATCHDOG_RESET_INPUT_N), .tick(wdt_tick),
    .len(wdt_len(watchdog_input_filter_code_q)), .level(pins.wdt_n)
  );

  // ****************************************
  // Routing and stop delays
  // ****************************************
  ids_pkg::ids_route_t route;
  logic global_on;
  logic hold3;
  logic hold4;

  assign route = route_of(input_a_function_code_q, pins.in_a) | route_of(input_b_function_code_q, pins.in_b);
  assign global_on = pins.en | global_enable_q | route.global_enable;

  ids_stop_delay u_stop3 (
    .clk(CLK), .rst(RST), .src(global_on), .tick(step_tick),
    .code(out3_stop_delay_code_q), .hold(hold3)
  );

  ids_stop_delay u_stop4 (
    .clk(CLK), .rst(RST), .src(global_on), .tick(step_tick),
    .code(out4_stop_delay_code_q), .hold(hold4)
  );

  // ****************************************
  // Outputs
  // ****************************************
  logic [3:0] vsel_q, vsel_d;
  logic gvsel_q, gvsel_d;
  logic glp_q, glp_d;
  logic [1:0] lp_q, lp_d;
  logic wdt_q, wdt_d;

  always_comb begin
    out_en_d = out_enable_bits_q | route.en | {hold4, hold3, global_on, global_on};
    gvsel_d = route.global_voltage_select;
    vsel_d = route.vsel | {4{route.global_voltage_select}};
    glp_d = pins.lp | route.glb_lp;
    lp_d = route.lp | {2{glp_d}};
    wdt_d = pins.wdt_n;
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      out_en_q <= 4'h0;
      gvsel_q <= 1'b0;
      vsel_q <= 4'h0;
      glp_q <= 1'b0;
      lp_q <= 2'h0;
      wdt_q <= 1'b1;
    end else begin
      out_en_q <= out_en_d;
      gvsel_q <= gvsel_d;
      vsel_q <= vsel_d;
      glp_q <= glp_d;
      lp_q <= lp_d;
      wdt_q <= wdt_d;
    end
  end

  assign OUT_ENABLE = out_en_q;
  assign GLOBAL_VOLTAGE_SELECT = gvsel_q;
  assign OUT_VOLTAGE_SELECT = vsel_q;
  assign GLOBAL_LOW_POWER = glp_q;
  assign OUT_LOW_POWER = lp_q;
  assign WATCHDOG_RESET_N = wdt_q;

endmodule

`default_nettype wire

// *** test/ids_pin_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module ids_pin_host (
  input wire logic clk,
  output var ids_pkg::ids_pins_t pins
);
  // Idle levels: watchdog input high, the rest low
  initial pins = 5'h10;
  task automatic set(input int i, input logic v);
    @(posedge clk);
    pins[i] <= v;
  endtask
endmodule
`default_nettype wire

// *** test/ids_top_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module ids_top_chk #(
  parameter int unsigned WDT_CYCLES = 16
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic WB_ACK_O,
  input wire logic [31:0] WB_DAT_O,
  input wire logic [3:0] OUT_ENABLE,
  input wire logic GLOBAL_VOLTAGE_SELECT,
  input wire logic [3:0] OUT_VOLTAGE_SELECT,
  input wire logic GLOBAL_LOW_POWER,
  input wire logic [1:0] OUT_LOW_POWER,
  input wire logic WATCHDOG_RESET_INPUT_N,
  input wire logic WATCHDOG_RESET_N
);
  logic [31:0] lo_q, lo_d;
  // Saturates so a long hold never wraps to a small count
  always_comb begin
    lo_d = WATCHDOG_RESET_INPUT_N ? 32'h0 : ((&lo_q) ? lo_q : lo_q + 32'h1);
  end
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      lo_q <= 32'h0;
    end else begin
      lo_q <= lo_d;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  sequence req_s;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  sequence pulse_s;
    WB_ACK_O ##1 !WB_ACK_O;
  endsequence
  chk_ack_answer: assert property (req_s |=> pulse_s)
    else $error("ack is not a one cycle answer");
  chk_ack_cause: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
    else $error("ack without request");
  chk_dat_hold: assert property (!(WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_WE_I) |=> $stable(WB_DAT_O))
    else $error("read data moved without read");
  chk_vsel_or: assert property (GLOBAL_VOLTAGE_SELECT |-> OUT_VOLTAGE_SELECT == 4'hF)
    else $error("global select not spread");
  chk_lp_or: assert property (GLOBAL_LOW_POWER |-> OUT_LOW_POWER == 2'h3)
    else $error("global low power not spread");
  chk_wdt_pass: assert property ($rose(WATCHDOG_RESET_N) |-> $past(WATCHDOG_RESET_INPUT_N, 5))
    else $error("watchdog rose without input");
  chk_wdt_hold: assert property ($fell(WATCHDOG_RESET_N) |-> lo_q >= 2 * WDT_CYCLES)
    else $error("watchdog filter too short");
  chk_rst_vals: assert property ($past(RST) |-> OUT_ENABLE == 4'h0 && WATCHDOG_RESET_N)
    else $error("outputs not idle after reset");
endmodule
bind ids_top ids_top_chk #(.WDT_CYCLES(WDT_CYCLES)) chk_i (.*);
`default_nettype wire

// *** test/tb_input_debounce_and_shutdown_delay.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_input_debounce_and_shutdown_delay;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] lf = 32'hD6EA161E;
  logic [31:0] rq;
  wire logic [31:0] dato;
  wire logic ack;
  wire logic [12:0] obs;
  wire ids_pkg::ids_pins_t pins;
  int err_count = 0;
  int n_checks = 0;
  int cycles = 0;
  int mdl[6] = '{32'h0, 32'h0, 32'h2, 32'h43, 32'h11, 32'h11};
  int msk[6] = '{32'h1F, 32'h1F, 32'h7, 32'hFF, 32'hFF, 32'hFF};
  ids_pin_host host (.clk(CLK), .pins(pins));
  ids_top #(.FILTER_CYCLES(8), .WDT_CYCLES(16), .STEP_CYCLES(20)) uut (
    .CLK(CLK), .RST(RST), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(dato), .WB_ACK_O(ack),
    .ENABLE_PIN(pins.en), .LOW_POWER_PIN(pins.lp), .WATCHDOG_RESET_INPUT_N(pins.wdt_n),
    .GENERAL_INPUT_A(pins.in_a), .GENERAL_INPUT_B(pins.in_b), .OUT_ENABLE(obs[3:0]),
    .GLOBAL_VOLTAGE_SELECT(obs[8]), .OUT_VOLTAGE_SELECT(obs[7:4]), .GLOBAL_LOW_POWER(obs[11]),
    .OUT_LOW_POWER(obs[10:9]), .WATCHDOG_RESET_N(obs[12]));
  always #2.5 CLK = ~CLK;
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Outputs expected while the routed input is high
  function automatic logic [12:0] route(input int c);
    route = 13'h1000;
    if (c == 0) route[3:0] = 4'hF;
    else if (c <= 4) route[c - 1] = 1'b1;
    else if (c == 5) route[8:4] = 5'h1F;
    else if (c <= 9) route[c - 2] = 1'b1;
    else if (c == 10) route[11:9] = 3'h7;
    else if (c <= 12) route[c - 2] = 1'b1;
  endfunction
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("mismatch at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge CLK);
    end while (ack !== 1'b1);
    rq = dato;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rq, e);
  endtask
  task automatic meas(input int b, input logic v, input int lo, input int hi);
    int k;
    k = 0;
    while (obs[b] !== v && k < 3000) begin
      @(posedge CLK);
      k++;
    end
    chk(32'(k >= lo && k <= hi), 32'h1);
  endtask
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      report_and_stop();
    end
  end
  initial begin
    repeat (8) @(posedge CLK);
    RST <= 1'b0;
    for (int i = 0; i < 6; i++) rd(8'h30 + 8'(4 * i), mdl[i]); // values after reset
    rd(8'hFC, 32'h0);
    rd(8'h18, 32'h0); // control bits clear
    rd(8'h1C, 32'h0); // step select clear
    rd(8'h60, 32'h100); // status idle levels
    host.set(2, 1'b1);
    repeat (40) @(posedge CLK);
    chk(32'(obs[3:0]), 32'h4); // input a on output 3
    rd(8'h60, 32'h144); // filtered input a in status
    host.set(2, 1'b0);
    host.set(3, 1'b1);
    repeat (40) @(posedge CLK);
    chk(32'(obs[3:0]), 32'h8); // input b on output 4
    host.set(3, 1'b0);
    for (int i = 0; i < 6; i++) begin
      if (i != 2) begin
        lf = nxt(lf);
        bus(1'b1, 8'h30 + 8'(4 * i), lf);
        mdl[i] = int'(lf) & msk[i];
        rd(8'h30 + 8'(4 * i), mdl[i]); // stored field only
      end
    end
    bus(1'b1, 8'h30, 32'h0);
    bus(1'b1, 8'h34, 32'h0);
    bus(1'b1, 8'h44, 32'h10);
    for (int c = 0; c < 16; c++) begin
      bus(1'b1, 8'h3C, 32'hF0 | 32'(c));
      host.set(2, 1'b1);
      repeat (20) @(posedge CLK);
      chk(32'(obs), 32'(route(c))); // routing per code
      host.set(2, 1'b0);
      repeat (20) @(posedge CLK);
      chk(32'(obs), 32'h1000); // unfiltered release
    end
    for (int s = 0; s < 2; s++) begin
      bus(1'b1, 8'h1C, 32'(s) << 7);
      rd(8'h1C, 32'(s) << 7); // step select stored
      bus(1'b1, 8'h30, 32'h3);
      bus(1'b1, 8'h34, 32'h1);
      bus(1'b1, 8'h18, 32'h1);
      repeat (10) @(posedge CLK);
      chk(32'(obs[3:0]), 32'hF); // global on
      bus(1'b1, 8'h18, 32'h0);
      fork
        meas(2, 1'b0, 60 * (s + 1), 80 * (s + 1) + 6); // output 3 stop
        meas(3, 1'b0, 20 * (s + 1), 40 * (s + 1) + 6); // output 4 stop
        meas(0, 1'b0, 0, 4); // output 1 at once
      join
    end
    bus(1'b1, 8'h3C, 32'hF1);
    bus(1'b1, 8'h44, 32'h1F);
    host.set(2, 1'b1);
    repeat (112) @(posedge CLK);
    host.set(2, 1'b0);
    repeat (30) @(posedge CLK);
    chk(32'(obs[0]), 32'h0); // short pulse dropped
    host.set(2, 1'b1);
    meas(0, 1'b1, 120, 136); // longest code
    host.set(2, 1'b0);
    meas(0, 1'b0, 120, 136); // longest code
    for (int k = 0; k < 9; k += 8) begin
      bus(1'b1, 8'h40, 32'(k * 17));
      host.set(0, 1'b1);
      meas(0, 1'b1, 8 * k, 8 * k + 16); // enable pin filter
      host.set(1, 1'b1);
      meas(11, 1'b1, 8 * k, 8 * k + 16); // low power pin filter
      host.set(0, 1'b0);
      host.set(1, 1'b0);
      repeat (100) @(posedge CLK);
    end
    host.set(4, 1'b0);
    repeat (20) @(posedge CLK);
    host.set(4, 1'b1);
    repeat (60) @(posedge CLK);
    chk(32'(obs[12]), 32'h1); // short low dropped
    host.set(4, 1'b0);
    meas(12, 1'b0, 32, 56); // default code two units
    host.set(4, 1'b1);
    meas(12, 1'b1, 32, 56); // default code two units
    report_and_stop();
  end
endmodule
`default_nettype wire
